// file: core/flash_sr_pkg.sv
/*
 Constants shared by the serial flash status-write device end and the
 SPI host end: command codes, status bit positions, reset values, host
 register offsets and link timing.
 Assumes both ends run on the same core_clk and meet in flash_link_if.
*/
// Functional notes
// RL1 - Reset enable clears at power-up; reset ignored
// RL2 - Reset command acts while enable is one
// RL3 - Enable kept across reset; only write changes
// RL4 - Byte two: bit4 enable, bit0 busy, rest zero
// RL5 - Second write touches only bit four
// RL6 - Host sends 01h then one data byte
// RL7 - First write: bit7 lock, bit2 protect only
// RL8 - Host sends write enable before first write
// RL9 - Extra bytes after first write are dropped
// RL10 - Release after valid first write updates, clears latch
// RL11 - Short or misaligned first write aborts, clears latch
// RL12 - Protection change depends on lock and pin
// RL13 - Pin asserted: lock only rises, else ignored
// RL14 - Host sends 31h then one data byte
// RL15 - Second write: bit4 is new enable
// RL16 - Only second write changes reset enable
// RL17 - Host sends write enable before second write
// RL18 - Release after valid second write updates, clears latch
// RL19 - Short or misaligned second write keeps enable
// RL20 - Extra bytes after second write are dropped
// RL21 - Latch clear refuses both status writes
// RL22 - First byte writable only at bits seven, two
// RL23 - MSB first, sampled on rising clock, select low
package flash_sr_pkg;

    // Command codes
    localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_RESET         = 8'hF0;

    // Status bit positions
    localparam int LOCK_BIT    = 7;
    localparam int PROTECT_BIT = 2;
    localparam int RCE_BIT     = 4;
    localparam int BUSY_BIT    = 0;

    // Reset values
    localparam logic       LOCK_RESET    = 1'b0;
    localparam logic       PROTECT_RESET = 1'b0;
    localparam logic       LATCH_RESET   = 1'b0;
    localparam logic       RCE_RESET     = 1'b0;
    localparam logic [3:0] PIN_RESET     = 4'hC;

    // Host register offsets and control fields
    localparam logic [3:0] ADDR_SHIFT_DATA = 4'h0;
    localparam logic [3:0] ADDR_CONTROL    = 4'h4;
    localparam logic [3:0] ADDR_STATUS     = 4'h8;
    localparam int         CTRL_COUNT_LSB  = 0;
    localparam int         CTRL_COUNT_W    = 6;
    localparam int         CTRL_START_BIT  = 8;
    localparam logic [5:0] MAX_BITS        = 6'h20;

    // Link timing in core_clk cycles per half serial clock
    localparam int SCK_HALF_CYCLES = 4;
    localparam int SCK_HALF_MIN    = 4;
    localparam int SCK_HALF_MAX    = 255;

endpackage

// file: core/flash_link_if.sv
/*
 Serial link between the SPI host end and the flash device end.
 Assumes one core_clk for both ends; the device samples these lines as pins.
*/
`timescale 1ns/1ps
interface flash_link_if;
    logic cs_n;
    logic sck;
    logic si;

    modport host   (output cs_n, output sck, output si);
    modport device (input cs_n, input sck, input si);
endinterface

// file: core/flash_sr_device.sv
/*
 Device end: status-register write logic of a serial flash.
 Decodes write enable/disable, both status writes and the reset command
 from the serial link and holds lock, protect, latch and reset enable.
 Assumes link and write-protect pins are asynchronous to core_clk and
 that busy_in comes from logic on core_clk.
*/
`timescale 1ns/1ps
module flash_sr_device
    import flash_sr_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Serial link
    flash_link_if.device    link,
    // Pins and core state
    input  wire logic       wp_n,
    input  wire logic       busy_in,
    // Status view
    output logic            protect_lock,
    output logic            block_protect,
    output logic            write_enable_latch,
    output logic            reset_cmd_enable,
    output logic [7:0]      status_second_byte,
    output logic            reset_cmd_pulse
);

    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] pin_r;
    logic       sck_d_r;
    logic       cs_d_r;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [2:0] bit_cnt_r;
    logic [1:0] byte_cnt_r;
    logic [7:0] opcode_r;
    logic [7:0] data_r;
    logic       lock_r;
    logic       protect_r;
    logic       latch_r;
    logic       rce_r;
    logic [7:0] stat2_r;
    logic       rst_pulse_r;

    logic wp_f;
    logic cs_f;
    logic sck_f;
    logic si_f;
    logic sck_rise;
    logic cs_rise;
    logic on_boundary;
    logic op_done;
    logic data_done;
    logic wsr1_ok;
    logic wsr2_ok;

    // A pin change is taken once the second and third stages agree
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_r <= PIN_RESET;
            sync2_r <= PIN_RESET;
            sync3_r <= PIN_RESET;
            pin_r   <= PIN_RESET;
        end
        else
        begin
            sync1_r <= {wp_n, link.cs_n, link.sck, link.si};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_r   <= (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));
        end
    end

    assign wp_f  = pin_r[3];
    assign cs_f  = pin_r[2];
    assign sck_f = pin_r[1];
    assign si_f  = pin_r[0];

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sck_d_r <= 1'b0;
            cs_d_r  <= 1'b1;
        end
        else
        begin
            sck_d_r <= sck_f;
            cs_d_r  <= cs_f;
        end
    end

    assign sck_rise  = sck_f & ~sck_d_r & ~cs_f; // see RL23
    assign cs_rise   = cs_f & ~cs_d_r;
    assign shift_nxt = {shift_r[6:0], si_f}; // see RL23

    // Frame counters clear while select is high; evaluation at the
    // release edge still sees the counts of the frame just ended.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_r    <= 8'h00;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            opcode_r   <= 8'h00;
            data_r     <= 8'h00;
        end
        else if (cs_f)
        begin
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
        end
        else if (sck_rise)
        begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
            begin
                if (byte_cnt_r == 2'h0)
                    opcode_r <= shift_nxt;
                if (byte_cnt_r == 2'h1)
                    data_r <= shift_nxt;
                // Counting stops at two, so later bytes are dropped
                if (byte_cnt_r != 2'h2)
                    byte_cnt_r <= byte_cnt_r + 2'h1; // see RL9, RL20
            end
        end
    end

    assign on_boundary = (bit_cnt_r == 3'h0);
    assign op_done     = (byte_cnt_r != 2'h0);
    assign data_done   = (byte_cnt_r == 2'h2) & on_boundary; // see RL11, RL19
    assign wsr1_ok = cs_rise & latch_r & data_done
                   & (opcode_r == OP_WRITE_STATUS1); // see RL10, RL21
    assign wsr2_ok = cs_rise & latch_r & data_done
                   & (opcode_r == OP_WRITE_STATUS2); // see RL18, RL21

    // Write-enable latch; an incomplete opcode leaves it alone
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            latch_r <= LATCH_RESET;
        else if (cs_rise && op_done)
        begin
            case (opcode_r)
                OP_WRITE_ENABLE:
                    if (on_boundary)
                        latch_r <= 1'b1;
                OP_WRITE_DISABLE:
                    if (on_boundary)
                        latch_r <= 1'b0;
                OP_WRITE_STATUS1,
                OP_WRITE_STATUS2:
                    latch_r <= 1'b0; // see RL10, RL11, RL13, RL18, RL19
                OP_RESET:
                    if (on_boundary && rce_r)
                        latch_r <= 1'b0; // see RL2
                default:
                    latch_r <= latch_r;
            endcase
        end
    end

    // With the pin asserted and lock held, lock cannot fall and protect
    // is frozen, so the whole write is dropped.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_r    <= LOCK_RESET;
            protect_r <= PROTECT_RESET;
        end
        else if (wsr1_ok && !(!wp_f && lock_r)) // see RL12, RL13
        begin
            lock_r    <= data_r[LOCK_BIT]; // see RL7, RL22
            protect_r <= data_r[PROTECT_BIT]; // see RL7, RL22
        end
    end

    // Reset enable changes through the second status write alone
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rce_r <= RCE_RESET; // see RL1
        else if (wsr2_ok)
            rce_r <= data_r[RCE_BIT]; // see RL15, RL16, RL3, RL5
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_pulse_r <= 1'b0;
        else
            rst_pulse_r <= cs_rise & op_done & on_boundary & rce_r
                         & (opcode_r == OP_RESET); // see RL1, RL2
    end

    // Reserved bits, bit 3 among them, read as zero
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            stat2_r <= 8'h00;
        else
        begin
            stat2_r           <= 8'h00; // see RL4
            stat2_r[RCE_BIT]  <= rce_r;
            stat2_r[BUSY_BIT] <= busy_in; // see RL4
        end
    end

    assign protect_lock       = lock_r;
    assign block_protect      = protect_r;
    assign write_enable_latch = latch_r;
    assign reset_cmd_enable   = rce_r;
    assign status_second_byte = stat2_r;
    assign reset_cmd_pulse    = rst_pulse_r;

endmodule

// file: core/flash_sr_host.sv
/*
 Host end: SPI master that shifts a software-loaded word out MSB first,
 mode 0, with a chosen number of bits per frame.
 Assumes a plain register port on core_clk and one device on the link.
*/
`timescale 1ns/1ps
module flash_sr_host
    import flash_sr_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_CYCLES
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    // Serial link
    flash_link_if.host       link
);

    if (SCK_HALF < SCK_HALF_MIN || SCK_HALF > SCK_HALF_MAX)
        $error("SCK_HALF outside the range the device sampler can follow");

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_LEAD = 5'b00010,
        H_HIGH = 5'b00100,
        H_LOW  = 5'b01000,
        H_TAIL = 5'b10000
    } host_state_e;

    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

    host_state_e state_r;
    logic [31:0] word_r;
    logic [5:0]  count_r;
    logic [5:0]  left_r;
    logic [7:0]  timer_r;
    logic        gap_r;
    logic        cs_n_r;
    logic        sck_r;
    logic        si_r;
    logic [31:0] rd_data_r;
    logic        half_done;
    logic        busy;
    logic        start;

    assign half_done = (timer_r == HALF_LAST);
    assign busy      = (state_r != H_IDLE) | gap_r;
    assign start     = wr_en & (addr == ADDR_CONTROL) & ~busy
                     & wr_data[CTRL_START_BIT]
                     & (wr_data[CTRL_COUNT_LSB +: CTRL_COUNT_W] != 6'h00)
                     & (wr_data[CTRL_COUNT_LSB +: CTRL_COUNT_W] <= MAX_BITS);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            word_r  <= 32'h0000_0000;
            count_r <= 6'h00;
        end
        else if (wr_en && !busy)
        begin
            if (addr == ADDR_SHIFT_DATA)
                word_r <= wr_data;
            if (addr == ADDR_CONTROL)
                count_r <= wr_data[CTRL_COUNT_LSB +: CTRL_COUNT_W];
        end
    end

    // Data changes on the falling clock so the device samples it stable
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= H_IDLE;
            timer_r <= 8'h00;
            left_r  <= 6'h00;
            gap_r   <= 1'b0;
            cs_n_r  <= 1'b1;
            sck_r   <= 1'b0;
            si_r    <= 1'b0;
        end
        else
        begin
            timer_r <= half_done ? 8'h00 : timer_r + 8'h01;
            case (state_r)
                H_IDLE:
                begin
                    if (gap_r && half_done)
                        gap_r <= 1'b0;
                    if (start)
                    begin
                        state_r <= H_LEAD;
                        timer_r <= 8'h00;
                        left_r  <= wr_data[CTRL_COUNT_LSB +: CTRL_COUNT_W];
                        cs_n_r  <= 1'b0;
                        si_r    <= word_r[31]; // see RL23, RL6, RL14
                    end
                end
                H_LEAD,
                H_LOW:
                    if (half_done)
                    begin
                        state_r <= H_HIGH;
                        sck_r   <= 1'b1;
                    end
                H_HIGH:
                    if (half_done)
                    begin
                        sck_r  <= 1'b0;
                        left_r <= left_r - 6'h01;
                        // Five-bit index keeps a full 32-bit frame in range
                        si_r   <= word_r[5'h1F - 5'(count_r - left_r + 6'h01)];
                        state_r <= (left_r == 6'h01) ? H_TAIL : H_LOW;
                    end
                H_TAIL:
                    if (half_done)
                    begin
                        state_r <= H_IDLE;
                        cs_n_r  <= 1'b1;
                        si_r    <= 1'b0;
                        gap_r   <= 1'b1;
                    end
                default:
                    state_r <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rd_data_r <= 32'h0000_0000;
        else if (rd_en)
        begin
            case (addr)
                ADDR_SHIFT_DATA: rd_data_r <= word_r;
                ADDR_CONTROL:    rd_data_r <= {26'h0, count_r};
                ADDR_STATUS:     rd_data_r <= {31'h0, busy};
                default:         rd_data_r <= 32'h0000_0000;
            endcase
        end
        else
            rd_data_r <= 32'h0000_0000;
    end

    assign rd_data   = rd_data_r;
    assign link.cs_n = cs_n_r;
    assign link.sck  = sck_r;
    assign link.si   = si_r;

endmodule

// file: tb/flash_sr_properties.sv
/*
 Checker for the serial link and the device status outputs.
 Assumes the host runs with a half period of 4 core_clk cycles and the
 bench holds wp_n steady while a frame is evaluated.
*/
`timescale 1ns/1ps
module flash_sr_checker (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // Serial link
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       si,
    // Device pins and status
    input wire logic       wp_n,
    input wire logic       busy_in,
    input wire logic       protect_lock,
    input wire logic       block_protect,
    input wire logic       write_enable_latch,
    input wire logic       reset_cmd_enable,
    input wire logic [7:0] status_second_byte,
    input wire logic       reset_cmd_pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence lead_low;
        !sck[*4];
    endsequence
    sequence half_high;
        sck[*4] ##1 !sck;
    endsequence

    sck_idle_a:
        assert property (cs_n |-> !sck) else $error("clock high off frame");
    data_edge_a:
        assert property ($changed(si) |-> $fell(sck) || $changed(cs_n))
            else $error("data moved off falling clock");
    frame_lead_a:
        assert property ($fell(cs_n) |-> lead_low ##1 sck)
            else $error("frame lead wrong");
    half_period_a:
        assert property ($rose(sck) |-> half_high)
            else $error("clock high time wrong");
    enable_change_a:
        assert property ($changed(reset_cmd_enable) |-> $fell(write_enable_latch))
            else $error("reset enable moved without status write");
    lock_change_a:
        assert property ($changed(protect_lock) || $changed(block_protect)
            |-> $fell(write_enable_latch)) else $error("lock moved alone");
    lock_pin_a:
        assert property ($fell(protect_lock) |-> wp_n)
            else $error("lock cleared with pin asserted");
    status_map_a:
        assert property (status_second_byte == {3'h0, $past(reset_cmd_enable),
            3'h0, $past(busy_in)}) else $error("status byte two wrong");
    pulse_gate_a:
        assert property (reset_cmd_pulse |-> reset_cmd_enable ##1 !reset_cmd_pulse)
            else $error("reset pulse wrong");
    update_release_a:
        assert property ($changed(write_enable_latch) |-> cs_n)
            else $error("latch moved inside frame");
endmodule

// file: tb/tb_flash_status_register_writes.sv
/*
 Testbench: drives the host register port, checks device status outputs.
 Assumes both ends share core_clk and the host half period is 4.
*/
`timescale 1ns/1ps
module tb_flash_status_register_writes;
    import flash_sr_pkg::*;
    logic        core_clk;
    logic        reset_n;
    logic [3:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        wp_n;
    logic        busy_in;
    logic        protect_lock;
    logic        block_protect;
    logic        write_enable_latch;
    logic        reset_cmd_enable;
    logic [7:0]  status_second_byte;
    logic        reset_cmd_pulse;
    logic [31:0] rdv;
    int          n_fail;
    int          n_tests;
    int          n_pulse;
    int          n_cyc;

    flash_link_if flash_link_if_i ();
    flash_sr_host #(.SCK_HALF(4)) flash_sr_host_i (.core_clk(core_clk),
        .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .link(flash_link_if_i.host));
    flash_sr_device flash_sr_device_i (.core_clk(core_clk),
        .reset_n(reset_n), .link(flash_link_if_i.device), .wp_n(wp_n),
        .busy_in(busy_in), .protect_lock(protect_lock),
        .block_protect(block_protect),
        .write_enable_latch(write_enable_latch),
        .reset_cmd_enable(reset_cmd_enable),
        .status_second_byte(status_second_byte),
        .reset_cmd_pulse(reset_cmd_pulse));
    flash_sr_checker flash_sr_checker_i (.core_clk(core_clk),
        .reset_n(reset_n), .cs_n(flash_link_if_i.cs_n),
        .sck(flash_link_if_i.sck), .si(flash_link_if_i.si), .wp_n(wp_n),
        .busy_in(busy_in), .protect_lock(protect_lock),
        .block_protect(block_protect),
        .write_enable_latch(write_enable_latch),
        .reset_cmd_enable(reset_cmd_enable),
        .status_second_byte(status_second_byte),
        .reset_cmd_pulse(reset_cmd_pulse));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Ceiling covers about 170 frames with polling, near eight times the 22 frames run
    always @(posedge core_clk)
    begin
        if (reset_cmd_pulse === 1'b1)
            n_pulse = n_pulse + 1;
        n_cyc = n_cyc + 1;
        if (n_cyc == 20000)
        begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Packed as lock, protect, latch, reset enable
    task automatic chk_st(input logic [3:0] exp);
        chk({4'h0, protect_lock, block_protect, write_enable_latch,
            reset_cmd_enable}, {4'h0, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // Waits out busy, then the device's release evaluation
    task automatic frame(input logic [31:0] w, input logic [5:0] n);
        int k;
        wr(ADDR_SHIFT_DATA, w);
        wr(ADDR_CONTROL, {23'h0, 1'b1, 2'h0, n});
        for (k = 0; k < 200; k++)
        begin
            rd(ADDR_STATUS, rdv);
            if (rdv[0] === 1'b0)
                break;
        end
        repeat (8) @(posedge core_clk);
    endtask

    task automatic wen();
        frame({OP_WRITE_ENABLE, 24'h0}, 6'h08);
    endtask

    task automatic note(input string s);
        $display("test %0s done", s);
    endtask

    initial
    begin
        reset_n = 1'b0;
        addr = 4'h0;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wp_n = 1'b1;
        busy_in = 1'b0;
        n_fail = 0;
        n_tests = 0;
        n_pulse = 0;
        n_cyc = 0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        chk_st(4'h0);
        chk(status_second_byte, 8'h00);
        rd(4'hC, rdv);
        chk(rdv[7:0], 8'h00);
        frame({OP_RESET, 24'h0}, 6'h08);
        chk(n_pulse[7:0], 8'h00);
        frame({OP_WRITE_STATUS2, 8'hFF, 16'h0}, 6'h10);
        chk_st(4'h0);
        note("power-up");
        wen();
        chk_st(4'h2);
        frame({OP_WRITE_STATUS2, 8'hFF, 16'h0}, 6'h18);
        chk_st(4'h1);
        chk(status_second_byte, 8'h10);
        wen();
        frame({OP_RESET, 24'h0}, 6'h08);
        chk(n_pulse[7:0], 8'h01);
        chk_st(4'h1);
        wen();
        frame({OP_WRITE_STATUS2, 8'h00, 16'h0}, 6'h0C);
        chk_st(4'h1);
        wen();
        frame({OP_WRITE_STATUS2, 24'h0}, 6'h04);
        chk_st(4'h3);
        frame({OP_WRITE_DISABLE, 24'h0}, 6'h08);
        chk_st(4'h1);
        frame({OP_WRITE_STATUS2, 24'h0}, 6'h10);
        chk_st(4'h1);
        note("second byte");
        wen();
        frame({OP_WRITE_STATUS1, 8'hFF, 16'h0}, 6'h18);
        chk_st(4'hD);
        wen();
        frame({OP_WRITE_STATUS1, 8'h00, 16'h0}, 6'h14);
        chk_st(4'hD);
        @(posedge core_clk) wp_n <= 1'b0;
        wen();
        frame({OP_WRITE_STATUS1, 8'h00, 16'h0}, 6'h10);
        chk_st(4'hD);
        @(posedge core_clk) wp_n <= 1'b1;
        wen();
        frame({OP_WRITE_STATUS1, 8'h7B, 16'h0}, 6'h10);
        chk_st(4'h1);
        @(posedge core_clk) wp_n <= 1'b0;
        wen();
        frame({OP_WRITE_STATUS1, 8'h80, 16'h0}, 6'h10);
        chk_st(4'h9);
        note("first byte");
        @(posedge core_clk) busy_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(status_second_byte, 8'h11);
        busy_in <= 1'b0;
        note("busy copy");
        close_out();
    end
endmodule
